// *** include/pfm_pkg.sv ***
// Purpose: Shared constants for the pad function multiplexer
// Assumes: 32-bit APB register window, 14 pads, 22 shared lines
// Notes: Function index order fixes the crossbar encoding
package pfm_pkg;
   // Register byte addresses
   localparam logic [31:0] PAD_EN_ADDR = 32'h2013_2020;
   localparam logic [31:0] LINE_EN_ADDR = 32'h2013_2024;
   localparam logic [31:0] SEL0_ADDR = 32'h2013_2028;
   localparam logic [31:0] SEL1_ADDR = 32'h2013_202C;
   localparam logic [31:0] SEL2_ADDR = 32'h2013_2030;
   localparam logic [31:0] EXTRA_ADDR = 32'h2013_2034;
   localparam logic [31:0] STATUS_ADDR = 32'h2013_2038;
   // Writable bits and reset values
   localparam logic [31:0] PAD_EN_MASK = 32'h00FF_3730;
   localparam logic [31:0] LINE_EN_MASK = 32'h003F_FFFF;
   localparam logic [31:0] EXTRA_MASK = 32'h0000_0001;
   localparam logic [31:0] EN_RST = 32'h0000_0000;
   localparam logic [31:0] SEL_RST = 32'hFFFF_FFFF;
   // Pad enable field positions; PAD12_GP_BIT sits in the extra register
   localparam int DBG_LSB = 16;
   localparam int DBG_W = 8;
   localparam int RADIO_BIT = 13;
   localparam int PAD13_GP_BIT = 12;
   localparam int PAD1_GP_BIT = 10;
   localparam int PAD0_GP_BIT = 9;
   localparam int SLAVE_BIT = 8;
   localparam int SEL1_EN_BIT = 5;
   localparam int MASTER_BIT = 4;
   localparam int PAD12_GP_BIT = 0;
   // Sizes
   localparam int NUM_PADS = 14;
   localparam int NUM_LINES = 22;
   localparam int NUM_FN = 15;
   localparam int SEL_W = 4;
   localparam int NUM_RADIO = 12;
   localparam int NUM_PWM = 5;
   localparam int NUM_IIC = 4;
   // Shared function indices
   localparam int FN_U0_TX = 0;
   localparam int FN_U0_RX = 1;
   localparam int FN_U0_CTS = 2;
   localparam int FN_U1_RX = 5;
   localparam int FN_IIC_LSB = 6;
   localparam int FN_I0_SDA = 7;
   localparam int FN_PWM_LSB = 10;
   localparam logic [14:0] FN_IS_OUT = 15'h7C19;
   localparam logic [14:0] FN_IS_IIC = 15'h03C0;
   // Pads with fixed alternates
   localparam int PAD_DCLK = 0;
   localparam int PAD_DDAT = 1;
   localparam int PAD_CS1 = 2;
   localparam int PAD_CS0 = 3;
   localparam int PAD_SCK = 4;
   localparam int PAD_MISO = 5;
   localparam int PAD_MOSI = 6;
   localparam int PAD_BTX = 7;
   localparam int PAD_BRX = 8;
   localparam int PAD_P22 = 12;
   localparam int DBG_ON_BTX = 5;
   localparam int DBG_ON_BRX = 6;
   localparam int LINE_ON_P22 = 20;
   localparam int LINE_ON_CS1 = 0;
   // Per pad line and radio test mapping
   localparam int PAD_LINE [NUM_PADS] = '{0, 0, 0, 1, 2, 3, 4, 10, 11, 13, 14, 15, 20, 21};
   localparam logic [13:0] PAD_HAS_LINE = 14'h3FFC;
   localparam int PAD_RADIO [NUM_PADS] = '{0, 0, 0, 0, 0, 0, 0, 2, 3, 5, 0, 6, 11, 0};
   localparam logic [13:0] PAD_HAS_RADIO = 14'h1B80;
   // Winning column codes
   localparam logic [2:0] COL_DEF = 3'h0;
   localparam logic [2:0] COL_ALT1 = 3'h1;
   localparam logic [2:0] COL_ALT2 = 3'h2;
   localparam logic [2:0] COL_LINE = 3'h3;
   localparam logic [2:0] COL_RADIO = 3'h4;
endpackage

// *** hw/pfm_line_xbar.sv ***
// Purpose: Crossbar between shared lines and shared peripheral signals
// Assumes: Select codes at or above the function count mean no function
// Notes: Purely combinational; the caller registers the results
`timescale 1ns/1ps
module pfm_line_xbar #(
   parameter int NUM_LINES = pfm_pkg::NUM_LINES,
   parameter int NUM_FN = pfm_pkg::NUM_FN,
   parameter int SEL_W = pfm_pkg::SEL_W
) (
   input wire logic [NUM_LINES*SEL_W-1:0] lineSelect,
   input wire logic [NUM_LINES-1:0] lineEnable,
   input wire logic [NUM_LINES-1:0] lineIn,
   input wire logic [NUM_FN-1:0] fnOut,
   input wire logic [NUM_FN-1:0] fnOe,
   output logic [NUM_LINES-1:0] lineOut,
   output logic [NUM_LINES-1:0] lineOe,
   output logic [NUM_FN-1:0] funcIn
);
   // Direction tables are sized for the documented function set
   if (NUM_FN != $bits(pfm_pkg::FN_IS_OUT) || NUM_FN > (1 << SEL_W)) begin : g_chk
      $error("pfm_line_xbar: function count does not fit tables");
   end
   // Each line picks one function by its own index
   for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
      logic [SEL_W-1:0] sel;
      logic valid;
      assign sel = lineSelect[l*SEL_W +: SEL_W];
      assign valid = (int'(sel) < NUM_FN);
      assign lineOut[l] = valid ? fnOut[sel] : 1'b0;
      // Outputs drive always, IIC only while pulling low
      assign lineOe[l] = valid & (pfm_pkg::FN_IS_OUT[sel] |
                                  (pfm_pkg::FN_IS_IIC[sel] & fnOe[sel]));
   end
   // Inputs idle high; several lines on one input act as wired-and
   for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
      always_comb begin
         funcIn[f] = 1'b1;
         for (int l = 0; l < NUM_LINES; l++) begin
            if (lineEnable[l] && lineSelect[l*SEL_W +: SEL_W] == SEL_W'(f)) begin
               funcIn[f] = funcIn[f] & lineIn[l];
            end
         end
      end
   end
endmodule

// *** hw/pfm_apb_regs.sv ***
// Purpose: APB register file for pad and shared line selection
// Assumes: No wait states; read data captured in the setup cycle
// Notes: Reserved enable and extra bits read zero, unmapped addresses answer pslverr
`timescale 1ns/1ps
module pfm_apb_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [pfm_pkg::NUM_PADS-1:0] padLevel,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] padEnable,
   output logic [31:0] lineEnable,
   output logic [95:0] selWords,
   output logic [31:0] extraEnable
);
   typedef struct packed {
      logic [31:0] padEn;
      logic [31:0] lineEn;
      logic [95:0] sel;
      logic [31:0] extra;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } pfm_regs_s;
   pfm_regs_s s;
   pfm_regs_s next_s;
   // Decode in setup, answer in access, write at the access edge
   always_comb begin
      logic hit;
      hit = 1'b1;
      next_s = s;
      next_s.ready = 1'b0;
      next_s.err = 1'b0;
      if (psel && !penable) begin
         next_s.ready = 1'b1;
         next_s.rdata = 32'h0000_0000;
         case (paddr)
            pfm_pkg::PAD_EN_ADDR: next_s.rdata = s.padEn;
            pfm_pkg::LINE_EN_ADDR: next_s.rdata = s.lineEn;
            pfm_pkg::SEL0_ADDR: next_s.rdata = s.sel[31:0];
            pfm_pkg::SEL1_ADDR: next_s.rdata = s.sel[63:32];
            pfm_pkg::SEL2_ADDR: next_s.rdata = s.sel[95:64];
            pfm_pkg::EXTRA_ADDR: next_s.rdata = s.extra;
            pfm_pkg::STATUS_ADDR: next_s.rdata = 32'(padLevel);
            default: hit = 1'b0;
         endcase
         next_s.err = !hit;
      end
      if (psel && penable && s.ready && pwrite && !s.err) begin
         case (paddr)
            pfm_pkg::PAD_EN_ADDR: next_s.padEn = pwdata & pfm_pkg::PAD_EN_MASK;
            pfm_pkg::LINE_EN_ADDR: next_s.lineEn = pwdata & pfm_pkg::LINE_EN_MASK;
            pfm_pkg::SEL0_ADDR: next_s.sel[31:0] = pwdata;
            pfm_pkg::SEL1_ADDR: next_s.sel[63:32] = pwdata;
            pfm_pkg::SEL2_ADDR: next_s.sel[95:64] = pwdata;
            pfm_pkg::EXTRA_ADDR: next_s.extra = pwdata & pfm_pkg::EXTRA_MASK;
            default: next_s.extra = s.extra;
         endcase
      end
   end
   // Single state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{padEn: pfm_pkg::EN_RST, lineEn: pfm_pkg::EN_RST,
                sel: {3{pfm_pkg::SEL_RST}}, extra: pfm_pkg::EN_RST,
                rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0};
      end else begin
         s <= next_s;
      end
   end
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign padEnable = s.padEn;
   assign lineEnable = s.lineEn;
   assign selWords = s.sel;
   assign extraEnable = s.extra;

   property p_pad_write;
      @(posedge clk) disable iff (!rst_n)
      (psel && penable && pready && pwrite && paddr == pfm_pkg::PAD_EN_ADDR)
      |=> padEnable == ($past(pwdata) & pfm_pkg::PAD_EN_MASK);
   endproperty
   a_pad_write: assert property (p_pad_write) else $error("pad enable write lost");
endmodule

// *** hw/pfm_pad_function_mux.sv ***
// Purpose: Routes each pad to its default, alternate or shared function
// Assumes: Pad inputs are asynchronous; peripheral signals share clk
// Notes: Every pad output and enable is registered, adding one cycle
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module pfm_pad_function_mux (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pfm_pkg::NUM_PADS-1:0] padIn,
   output logic [pfm_pkg::NUM_PADS-1:0] padOut,
   output logic [pfm_pkg::NUM_PADS-1:0] padOe,
   input wire logic [pfm_pkg::NUM_PADS-1:0] gpioOut,
   input wire logic [pfm_pkg::NUM_PADS-1:0] gpioOe,
   output logic [pfm_pkg::NUM_PADS-1:0] gpioIn,
   output logic swdClk,
   input wire logic swdDataOut,
   input wire logic swdDataOe,
   output logic swdDataIn,
   input wire logic bridgeUartTx,
   output logic bridgeUartRx,
   input wire logic masterSelect0,
   input wire logic masterSelect1,
   input wire logic spiMasterClk,
   input wire logic spiMasterMosi,
   output logic spiMasterMiso,
   output logic slaveSelect,
   output logic slaveClk,
   output logic slaveMosi,
   input wire logic slaveMiso,
   input wire logic [pfm_pkg::DBG_W-1:0] linkDebug,
   output logic [pfm_pkg::NUM_RADIO-1:0] radioTest,
   input wire logic uart0Tx,
   input wire logic uart0Rts,
   output logic uart0Rx,
   output logic uart0Cts,
   input wire logic uart1Tx,
   output logic uart1Rx,
   input wire logic [pfm_pkg::NUM_IIC-1:0] iicPullLow,
   output logic [pfm_pkg::NUM_IIC-1:0] iicIn,
   input wire logic [pfm_pkg::NUM_PWM-1:0] pwm
);
   typedef struct packed {
      logic [pfm_pkg::NUM_PADS-1:0] sync1;
      logic [pfm_pkg::NUM_PADS-1:0] sync2;
      logic [pfm_pkg::NUM_PADS-1:0] padOut;
      logic [pfm_pkg::NUM_PADS-1:0] padOe;
      logic [pfm_pkg::NUM_PADS-1:0] gpioIn;
      logic [pfm_pkg::NUM_RADIO-1:0] radio;
      logic [pfm_pkg::NUM_IIC-1:0] iicIn;
      logic swdClk;
      logic swdDataIn;
      logic bridgeRx;
      logic miso;
      logic sSel;
      logic sClk;
      logic sMosi;
      logic u0Rx;
      logic u0Cts;
      logic u1Rx;
   } pfm_mux_s;
   pfm_mux_s s;
   pfm_mux_s next_s;

   logic [31:0] padEnable;
   logic [31:0] lineEnable;
   logic [95:0] selWords;
   logic [31:0] extraEnable;
   logic [pfm_pkg::NUM_LINES-1:0] lineIn;
   logic [pfm_pkg::NUM_LINES-1:0] lineOut;
   logic [pfm_pkg::NUM_LINES-1:0] lineOe;
   logic [pfm_pkg::NUM_FN-1:0] funcIn;
   logic [pfm_pkg::NUM_FN-1:0] fnOut;
   logic [pfm_pkg::NUM_FN-1:0] fnOe;
   logic [pfm_pkg::DBG_W-1:0] dbgEn;
   logic radioEn;
   logic masterEn;
   logic slaveEn;

   // Software view of the selection
   pfm_apb_regs u_regs (
      .clk(clk),
      .rst_n(rst_n),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .padLevel(s.sync2),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .padEnable(padEnable),
      .lineEnable(lineEnable),
      .selWords(selWords),
      .extraEnable(extraEnable)
   );

   // Enable fields pulled apart once
   assign dbgEn = padEnable[pfm_pkg::DBG_LSB +: pfm_pkg::DBG_W];
   assign radioEn = padEnable[pfm_pkg::RADIO_BIT];
   assign masterEn = padEnable[pfm_pkg::MASTER_BIT];
   assign slaveEn = padEnable[pfm_pkg::SLAVE_BIT];

   // Shared signals by index; inputs and iic data drive no level
   assign fnOut = {pwm, 4'h0, 1'b0, uart1Tx, uart0Rts, 2'h0, uart0Tx};
   assign fnOe = {5'h00, iicPullLow, 6'h00};

   // Lines without a pad read idle high so they never pull an input
   for (genvar l = 0; l < pfm_pkg::NUM_LINES; l++) begin : g_lin
      logic hasPad;
      logic level;
      always_comb begin
         hasPad = 1'b0;
         level = 1'b1;
         for (int k = 0; k < pfm_pkg::NUM_PADS; k++) begin
            if (pfm_pkg::PAD_HAS_LINE[k] && pfm_pkg::PAD_LINE[k] == l) begin
               hasPad = 1'b1;
               level = s.sync2[k];
            end
         end
      end
      assign lineIn[l] = hasPad ? level : 1'b1;
   end

   pfm_line_xbar #(
      .NUM_LINES(pfm_pkg::NUM_LINES),
      .NUM_FN(pfm_pkg::NUM_FN),
      .SEL_W(pfm_pkg::SEL_W)
   ) u_xbar (
      .lineSelect(selWords[pfm_pkg::NUM_LINES*pfm_pkg::SEL_W-1:0]),
      .lineEnable(lineEnable[pfm_pkg::NUM_LINES-1:0]),
      .lineIn(lineIn),
      .fnOut(fnOut),
      .fnOe(fnOe),
      .lineOut(lineOut),
      .lineOe(lineOe),
      .funcIn(funcIn)
   );

   // Per pad column choice; later checks are higher columns and win
   always_comb begin
      logic [2:0] col [pfm_pkg::NUM_PADS];
      logic o;
      logic e;
      col = '{default: pfm_pkg::COL_DEF};
      o = 1'b0;
      e = 1'b0;
      next_s = s;
      next_s.sync1 = padIn;
      next_s.sync2 = s.sync1;
      next_s.gpioIn = s.sync2;
      next_s.radio = '0;
      for (int k = 0; k < pfm_pkg::NUM_PADS; k++) begin
         o = gpioOut[k];
         e = gpioOe[k];
         case (k)
            pfm_pkg::PAD_DCLK: begin
               if (padEnable[pfm_pkg::PAD0_GP_BIT]) begin
                  col[k] = pfm_pkg::COL_ALT1;
               end else begin
                  e = 1'b0;
               end
            end
            pfm_pkg::PAD_DDAT: begin
               if (padEnable[pfm_pkg::PAD1_GP_BIT]) begin
                  col[k] = pfm_pkg::COL_ALT1;
               end else begin
                  o = swdDataOut;
                  e = swdDataOe;
               end
            end
            pfm_pkg::PAD_CS1: begin
               if (padEnable[pfm_pkg::SEL1_EN_BIT]) begin
                  col[k] = pfm_pkg::COL_ALT1;
                  o = masterSelect1;
                  e = 1'b1;
               end
            end
            pfm_pkg::PAD_CS0, pfm_pkg::PAD_SCK, pfm_pkg::PAD_MISO, pfm_pkg::PAD_MOSI: begin
               if (masterEn) begin
                  col[k] = pfm_pkg::COL_ALT1;
                  o = (k == pfm_pkg::PAD_CS0) ? masterSelect0 :
                      (k == pfm_pkg::PAD_SCK) ? spiMasterClk : spiMasterMosi;
                  e = (k != pfm_pkg::PAD_MISO);
               end
               if (slaveEn) begin
                  col[k] = pfm_pkg::COL_ALT2;
                  o = slaveMiso;
                  e = (k == pfm_pkg::PAD_MISO);
               end
            end
            pfm_pkg::PAD_BTX: begin
               if (extraEnable[pfm_pkg::PAD12_GP_BIT]) begin
                  col[k] = pfm_pkg::COL_ALT1;
               end else begin
                  o = bridgeUartTx;
                  e = 1'b1;
               end
               if (dbgEn[pfm_pkg::DBG_ON_BTX]) begin
                  col[k] = pfm_pkg::COL_ALT2;
                  o = linkDebug[pfm_pkg::DBG_ON_BTX];
                  e = 1'b1;
               end
            end
            pfm_pkg::PAD_BRX: begin
               if (padEnable[pfm_pkg::PAD13_GP_BIT]) begin
                  col[k] = pfm_pkg::COL_ALT1;
               end else begin
                  e = 1'b0;
               end
               if (dbgEn[pfm_pkg::DBG_ON_BRX]) begin
                  col[k] = pfm_pkg::COL_ALT2;
                  o = linkDebug[pfm_pkg::DBG_ON_BRX];
                  e = 1'b1;
               end
            end
            default: begin
               col[k] = pfm_pkg::COL_DEF;
            end
         endcase
         if (pfm_pkg::PAD_HAS_LINE[k] && lineEnable[pfm_pkg::PAD_LINE[k]]) begin
            col[k] = pfm_pkg::COL_LINE;
            o = lineOut[pfm_pkg::PAD_LINE[k]];
            e = lineOe[pfm_pkg::PAD_LINE[k]];
         end
         if (pfm_pkg::PAD_HAS_RADIO[k] && radioEn) begin
            col[k] = pfm_pkg::COL_RADIO;
            o = 1'b0;
            e = 1'b0;
            next_s.radio[pfm_pkg::PAD_RADIO[k]] = s.sync2[k];
         end
         next_s.padOut[k] = o;
         next_s.padOe[k] = e;
      end
      // Peripheral inputs see the pad only while their column wins
      next_s.swdClk = (col[pfm_pkg::PAD_DCLK] == pfm_pkg::COL_DEF) &
                      s.sync2[pfm_pkg::PAD_DCLK];
      next_s.swdDataIn = (col[pfm_pkg::PAD_DDAT] == pfm_pkg::COL_DEF) ?
                         s.sync2[pfm_pkg::PAD_DDAT] : 1'b1;
      next_s.bridgeRx = (col[pfm_pkg::PAD_BRX] == pfm_pkg::COL_DEF) ?
                        s.sync2[pfm_pkg::PAD_BRX] : 1'b1;
      next_s.miso = (col[pfm_pkg::PAD_MISO] == pfm_pkg::COL_ALT1) &
                    s.sync2[pfm_pkg::PAD_MISO];
      next_s.sSel = (col[pfm_pkg::PAD_CS0] == pfm_pkg::COL_ALT2) ?
                    s.sync2[pfm_pkg::PAD_CS0] : 1'b1;
      next_s.sClk = (col[pfm_pkg::PAD_SCK] == pfm_pkg::COL_ALT2) &
                    s.sync2[pfm_pkg::PAD_SCK];
      next_s.sMosi = (col[pfm_pkg::PAD_MOSI] == pfm_pkg::COL_ALT2) &
                     s.sync2[pfm_pkg::PAD_MOSI];
      // Shared inputs come back through the crossbar
      next_s.u0Rx = funcIn[pfm_pkg::FN_U0_RX];
      next_s.u0Cts = funcIn[pfm_pkg::FN_U0_CTS];
      next_s.u1Rx = funcIn[pfm_pkg::FN_U1_RX];
      next_s.iicIn = funcIn[pfm_pkg::FN_IIC_LSB +: pfm_pkg::NUM_IIC];
   end

   // Single state register; reset clears every pad enable, so every pad floats while in reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign padOut = s.padOut;
   assign padOe = s.padOe;
   assign gpioIn = s.gpioIn;
   assign swdClk = s.swdClk;
   assign swdDataIn = s.swdDataIn;
   assign bridgeUartRx = s.bridgeRx;
   assign spiMasterMiso = s.miso;
   assign slaveSelect = s.sSel;
   assign slaveClk = s.sClk;
   assign slaveMosi = s.sMosi;
   assign radioTest = s.radio;
   assign uart0Rx = s.u0Rx;
   assign uart0Cts = s.u0Cts;
   assign uart1Rx = s.u1Rx;
   assign iicIn = s.iicIn;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [pfm_pkg::SEL_W-1:0] selCs1;
   assign selCs1 = selWords[pfm_pkg::LINE_ON_CS1*pfm_pkg::SEL_W +: pfm_pkg::SEL_W];

   property p_radio_in;
      radioEn [*4] |-> radioTest[pfm_pkg::PAD_RADIO[pfm_pkg::PAD_P22]] == $past(padIn[pfm_pkg::PAD_P22], 3);
   endproperty
   a_radio_in: assert property (p_radio_in) else $error("radio test path wrong");
   property p_pad0_gp;
      padEnable[pfm_pkg::PAD0_GP_BIT] |=> padOut[0] == $past(gpioOut[0]) && padOe[0] == $past(gpioOe[0]);
   endproperty
   a_pad0_gp: assert property (p_pad0_gp) else $error("pad0 general path wrong");
   property p_line_on;
      lineEnable[pfm_pkg::LINE_ON_P22] && !radioEn |=>
         padOe[pfm_pkg::PAD_P22] == $past(lineOe[pfm_pkg::LINE_ON_P22]);
   endproperty
   a_line_on: assert property (p_line_on) else $error("shared line not on pad");
   property p_pwm_sel;
      lineEnable[pfm_pkg::LINE_ON_CS1] && selCs1 == pfm_pkg::SEL_W'(pfm_pkg::FN_PWM_LSB) |=>
         padOe[pfm_pkg::PAD_CS1] && padOut[pfm_pkg::PAD_CS1] == $past(pwm[0]);
   endproperty
   a_pwm_sel: assert property (p_pwm_sel) else $error("pwm index wrong");
   property p_iic_od;
      lineEnable[pfm_pkg::LINE_ON_CS1] && selCs1 == pfm_pkg::SEL_W'(pfm_pkg::FN_I0_SDA) |=>
         !padOut[pfm_pkg::PAD_CS1] && padOe[pfm_pkg::PAD_CS1] == $past(iicPullLow[1]);
   endproperty
   a_iic_od: assert property (p_iic_od) else $error("iic line not open drain");
   property p_rx_in;
      lineEnable[pfm_pkg::LINE_ON_CS1] && selCs1 == pfm_pkg::SEL_W'(pfm_pkg::FN_U0_RX) |=>
         !padOe[pfm_pkg::PAD_CS1];
   endproperty
   a_rx_in: assert property (p_rx_in) else $error("receive line driven");
   property p_master_cs;
      masterEn && !slaveEn && !lineEnable[pfm_pkg::PAD_LINE[pfm_pkg::PAD_CS0]] &&
      !lineEnable[pfm_pkg::PAD_LINE[pfm_pkg::PAD_MISO]] |=>
         padOe[pfm_pkg::PAD_CS0] && padOut[pfm_pkg::PAD_CS0] == $past(masterSelect0) &&
         !padOe[pfm_pkg::PAD_MISO];
   endproperty
   a_master_cs: assert property (p_master_cs) else $error("master pins wrong");
   property p_bridge_rx;
      (!padEnable[pfm_pkg::PAD13_GP_BIT] && !dbgEn[pfm_pkg::DBG_ON_BRX] &&
       !lineEnable[pfm_pkg::PAD_LINE[pfm_pkg::PAD_BRX]] && !radioEn) [*4]
      |-> bridgeUartRx == $past(padIn[pfm_pkg::PAD_BRX], 3) && !padOe[pfm_pkg::PAD_BRX];
   endproperty
   a_bridge_rx: assert property (p_bridge_rx) else $error("bridge rx path wrong");
   property p_slave_wins;
      masterEn && slaveEn && !lineEnable[pfm_pkg::PAD_LINE[pfm_pkg::PAD_MOSI]] &&
      !lineEnable[pfm_pkg::PAD_LINE[pfm_pkg::PAD_MISO]] |=>
         !padOe[pfm_pkg::PAD_MOSI] && padOe[pfm_pkg::PAD_MISO] ##0
         padOut[pfm_pkg::PAD_MISO] == $past(slaveMiso);
   endproperty
   a_slave_wins: assert property (p_slave_wins) else $error("column priority wrong");
endmodule

// *** dv/pfm_pad_model.sv ***
// Purpose: Pad-side model that resolves each pad level
// Assumes: A driven pad reads back its drive value
// Notes: An undriven pad toggles so a stale value never matches
`timescale 1ns/1ps
module pfm_pad_model (
   input wire logic clk,
   input wire logic [13:0] padOut,
   input wire logic [13:0] padOe,
   output logic [13:0] padIn
);
   logic [13:0] wob = 14'h1555;
   // Floating pads change every cycle
   always @(posedge clk) begin
      wob <= ~wob;
   end
   assign padIn = (padOe & padOut) | (~padOe & wob);
endmodule

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the pad function multiplexer
// Assumes: APB slave with no wait states; pad outputs add one cycle, pad inputs three
// Notes: Read results are queued and compared by a monitor
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [31:0] paddr = 0, pwdata = 0, prdata;
   logic swdClk, swdDataIn, bridgeUartRx, spiMasterMiso, slaveSelect, slaveClk, slaveMosi;
   logic swdDataOut = 0, swdDataOe = 0, bridgeUartTx = 0, masterSelect0 = 0, masterSelect1 = 0;
   logic spiMasterClk = 0, spiMasterMosi = 0, slaveMiso = 0, uart0Tx = 0, uart0Rts = 0;
   logic uart1Tx = 0, uart0Rx, uart0Cts, uart1Rx;
   logic [13:0] padIn, padOut, padOe, gpioOut = 0, gpioOe = 0, gpioIn;
   logic [7:0] linkDebug = 0;
   logic [11:0] radioTest;
   logic [3:0] iicPullLow = 0, iicIn;
   logic [4:0] pwm = 0;
   logic [14:0] fv;
   logic rx;
   logic [32:0] q[$];
   int n_mismatch = 0, checks = 0;
   pfm_pad_function_mux pfm_pad_function_mux_inst (.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .padIn, .padOut, .padOe, .gpioOut, .gpioOe,
      .gpioIn, .swdClk, .swdDataOut, .swdDataOe, .swdDataIn, .bridgeUartTx, .bridgeUartRx,
      .masterSelect0, .masterSelect1, .spiMasterClk, .spiMasterMosi, .spiMasterMiso,
      .slaveSelect, .slaveClk, .slaveMosi, .slaveMiso, .linkDebug, .radioTest, .uart0Tx,
      .uart0Rts, .uart0Rx, .uart0Cts, .uart1Tx, .uart1Rx, .iicPullLow, .iicIn, .pwm);
   pfm_pad_model pfm_pad_model_inst (.clk, .padOut, .padOe, .padIn);
   // Free-running clock
   always #2.5 clk = ~clk;
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // Request held until pready is seen at a rising edge, released right there
   task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) q.push_back(e);
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   // Read monitor takes the oldest note at the access edge
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk({pslverr, prdata}, q.pop_front());
      end
   end
   // New random peripheral levels; three edges cover the two sync flops and the output flop
   task automatic spin;
      @(posedge clk);
      {uart0Tx, uart0Rts, uart1Tx, pwm, iicPullLow, spiMasterClk, slaveMiso, bridgeUartTx,
         masterSelect0, masterSelect1, spiMasterMosi, linkDebug, gpioOe, gpioOut}
         <= 54'({$urandom, $urandom});
      repeat (3) @(posedge clk);
      #1;
      fv = {pwm, 5'h00, uart1Tx, uart0Rts, 2'h0, uart0Tx};
   endtask
   task automatic complete_run;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      void'($urandom(32'hC7B181EE));
      repeat (2) @(posedge clk);
      rst_n <= 1;
      apb(0, pfm_pkg::PAD_EN_ADDR, 0, {1'b0, pfm_pkg::EN_RST});
      apb(0, pfm_pkg::LINE_EN_ADDR, 0, {1'b0, pfm_pkg::EN_RST});
      apb(1, pfm_pkg::PAD_EN_ADDR, 32'hFFFF_FFFF, 0);
      apb(0, pfm_pkg::PAD_EN_ADDR, 0, {1'b0, pfm_pkg::PAD_EN_MASK});
      apb(1, pfm_pkg::LINE_EN_ADDR, 32'hFFFF_FFFF, 0);
      apb(0, pfm_pkg::LINE_EN_ADDR, 0, {1'b0, pfm_pkg::LINE_EN_MASK});
      apb(0, 32'h2013_203C, 0, {1'b1, 32'h0000_0000});
      apb(1, pfm_pkg::PAD_EN_ADDR, 0, 0);
      apb(1, pfm_pkg::LINE_EN_ADDR, 32'h0000_0003, 0);
      spin();
      chk({padOe[7], padOut[7]}, {1'b1, bridgeUartTx});
      // Every shared function on lines 0 and 1, which sit on pads P02 and P03
      for (int f = 0; f < 15; f++) begin
         apb(1, pfm_pkg::SEL0_ADDR, 32'hFFFF_FF00 | (32'(f) << 4) | 32'(f), 0);
         spin();
         chk(padOe[3:2], {2{pfm_pkg::FN_IS_IIC[f] ? iicPullLow[f-6] : pfm_pkg::FN_IS_OUT[f]}});
         if (pfm_pkg::FN_IS_OUT[f]) chk(padOut[3:2], {2{fv[f]}});
         // Undriven pads toggle, so the level three edges back is the inverse; two lines wire-and
         rx = !padIn[2] && !padIn[3];
         chk({uart0Rx, uart0Cts, uart1Rx}, {f != 1 || rx, f != 2 || rx, f != 5 || rx});
         if (!pfm_pkg::FN_IS_IIC[f]) chk(iicIn, 4'hF);
      end
      apb(1, pfm_pkg::LINE_EN_ADDR, 0, 0);
      apb(1, pfm_pkg::PAD_EN_ADDR, 32'h0000_0010, 0);
      spin();
      chk({padOe[6:3], padOut[6], padOut[4:3], spiMasterMiso},
          {4'hB, spiMasterMosi, spiMasterClk, masterSelect0, !padIn[5]});
      apb(1, pfm_pkg::PAD_EN_ADDR, 32'h0000_0110, 0);
      spin();
      chk({padOe[6:3], padOut[5]}, {4'h4, slaveMiso});
      chk({slaveSelect, slaveClk, slaveMosi, spiMasterMiso},
          {!padIn[3], !padIn[4], !padIn[6], 1'b0});
      apb(1, pfm_pkg::PAD_EN_ADDR, 32'h0020_0220, 0);
      spin();
      chk({padOe[0], padOut[0]}, {gpioOe[0], gpioOut[0]});
      chk({padOe[2], padOut[2], padOe[7], padOut[7]},
          {1'b1, masterSelect1, 1'b1, linkDebug[5]});
      chk({swdClk, swdDataIn, bridgeUartRx}, {1'b0, !padIn[1], !padIn[8]});
      complete_run();
   end
endmodule
